// ==== mct_card_model.sv ====
// Card data machine model: waits a given gap, then ends the block
`timescale 1ns/1ps
module mct_card_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command from the bench
  input wire logic req,
  input wire logic [23:0] gap,
  // Data path handshake
  output logic block_wait,
  output logic block_done,
  output logic busy
);
  logic [23:0] left; // Wait cycles still to go
  assign busy = block_wait | block_done;
  // Wait for gap plus one cycles, then a one-cycle done with wait low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_wait <= 1'b0;
      block_done <= 1'b0;
      left <= '0;
    end else if (req && !busy) begin
      block_wait <= 1'b1;
      left <= gap;
    end else if (block_wait && left == '0) begin
      block_wait <= 1'b0;
      block_done <= 1'b1;
    end else begin
      left <= left - 24'h1;
      block_done <= 1'b0;
    end
  end
endmodule : mct_card_model

// ==== mct_checker.sv ====
// Port checks of the card timeout and configuration block
`timescale 1ns/1ps
`include "mct_defs.svh"
module mct_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Card side
  input wire logic block_wait,
  input wire mct_pkg::mct_cfg_s card_cfg,
  input wire logic data_timeout_error,
  input wire logic irq
);
  import mct_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Both halves of a write taken at one edge
  wire wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Write aimed at a lockable register
  wire cfg_hit = s_axi_awaddr == `MCT_ADDR_TIMEOUT || s_axi_awaddr == `MCT_ADDR_SLOTWID;
  // Offered write word with unwritten bytes as zero
  wire [31:0] wr_lanes = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wr_word = s_axi_wdata & wr_lanes;
  // Lock state rebuilt from the bus, to judge config changes
  logic locked;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked <= 1'b0;
    end else if (wr_both && s_axi_awaddr == `MCT_ADDR_PROTECT &&
                 wr_word[`MCT_KEY_MSB:`MCT_KEY_LSB] == `MCT_KEY_VALUE) begin
      locked <= wr_word[`MCT_PEN_BIT];
    end
  end
  AST_B_LAT: assert property (wr_both |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_AW_LOW: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("second write taken early");
  AST_CFG_OKAY: assert property (
    wr_both && cfg_hit |-> ##2 s_axi_bresp == `MCT_RESP_OKAY) else $error("bad response");
  AST_DTO_STICKY: assert property (
    data_timeout_error && s_axi_awready |=> data_timeout_error) else $error("flag lost");
  AST_DTO_QUIET: assert property (
    !block_wait [*5] |=> !$rose(data_timeout_error)) else $error("flag without wait");
  AST_CFG_WRITE: assert property (
    $changed(card_cfg) |-> !$past(s_axi_awready) || !$past(s_axi_awready, 2))
    else $error("config changed without write");
  AST_CFG_LOCK: assert property ($changed(card_cfg) |-> !locked)
    else $error("config changed while locked");
  AST_KEY_ZERO: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `MCT_ADDR_PROTECT |=>
    s_axi_rdata[`MCT_KEY_MSB:`MCT_KEY_LSB] == 24'h0) else $error("key read back");
  // Main scenarios
  cover property (wr_both);
  cover property ($rose(data_timeout_error));
  cover property ($rose(irq));
  cover property ($rose(locked));
endmodule : mct_checker

bind mct_top mct_checker mct_checker_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_araddr(s_axi_araddr),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .block_wait(block_wait), .card_cfg(card_cfg),
  .data_timeout_error(data_timeout_error), .irq(irq));

// ==== mct_defs.svh ====
// Constants of the memory-card timeout and configuration block
`ifndef MCT_DEFS_SVH
`define MCT_DEFS_SVH

// Register byte addresses
`define MCT_ADDR_TIMEOUT 32'h4000_0008
`define MCT_ADDR_SLOTWID 32'h4000_000c
`define MCT_ADDR_PROTECT 32'h4000_00e4
`define MCT_ADDR_STATUS 32'h4000_0040
`define MCT_ADDR_IMASK 32'h4000_0044

// Timeout register fields
`define MCT_CYC_LSB 0
`define MCT_CYC_MSB 3
`define MCT_MUL_LSB 4
`define MCT_MUL_MSB 6

// Slot and width register fields
`define MCT_SLOT_LSB 0
`define MCT_SLOT_MSB 1
`define MCT_BUSW_LSB 6
`define MCT_BUSW_MSB 7

// Protection register fields and key
`define MCT_PEN_BIT 0
`define MCT_KEY_LSB 8
`define MCT_KEY_MSB 31
`define MCT_KEY_VALUE 24'h4d4349

// Status register bits
`define MCT_ST_DTO_BIT 0
`define MCT_ST_WAIT_BIT 1

// Multiplier shifts for codes 0 to 7: x1, x16, x128, x256, x1024, x4096, x65536, x1048576
`define MCT_SHIFT_0 5'h00
`define MCT_SHIFT_1 5'h04
`define MCT_SHIFT_2 5'h07
`define MCT_SHIFT_3 5'h08
`define MCT_SHIFT_4 5'h0a
`define MCT_SHIFT_5 5'h0c
`define MCT_SHIFT_6 5'h10
`define MCT_SHIFT_7 5'h14

// Widths and reset values
`define MCT_LIMIT_W 24
`define MCT_CFG_RESET 4'h0
`define MCT_RESP_OKAY 2'h0
`define MCT_RESP_SLVERR 2'h2

`endif

// ==== mct_pkg.sv ====
// Types shared by the memory-card timeout and configuration block
package mct_pkg;

  // Card bus width codes, code 1 is reserved
  typedef enum logic [1:0] {
    MCT_BUS_1BIT = 2'h0,
    MCT_BUS_RSVD = 2'h1,
    MCT_BUS_4BIT = 2'h2,
    MCT_BUS_8BIT = 2'h3
  } mct_busw_e;

  // Card slot codes
  typedef enum logic [1:0] {
    MCT_SLOT_A = 2'h0,
    MCT_SLOT_B = 2'h1,
    MCT_SLOT_C = 2'h2,
    MCT_SLOT_D = 2'h3
  } mct_slot_e;

  // Write channel sequencer, one-hot
  typedef enum logic [1:0] {
    MCT_WR_COLLECT = 2'b01,
    MCT_WR_RESP = 2'b10
  } mct_wr_e;

  // Card configuration presented to the card interface
  typedef struct packed {
    mct_slot_e card_slot_select;
    mct_busw_e card_bus_width;
    logic [2:0] timeout_multiplier_select;
    logic [3:0] timeout_cycle_count;
  } mct_cfg_s;

endpackage : mct_pkg

// ==== mct_sticky.sv ====
// Sticky event flags, cleared by writing one, with set winning over clear
`timescale 1ns/1ps
module mct_sticky #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events and clears
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flag state
  output logic [W-1:0] flag
);

  // Set beats clear so no event is lost in the clearing cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= '0;
    end else begin
      flag <= set | (flag & ~clr);
    end
  end

endmodule : mct_sticky

// ==== mct_timeout.sv ====
// Data timeout counter between successive data blocks
`timescale 1ns/1ps
`include "mct_defs.svh"
module mct_timeout (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [`MCT_LIMIT_W-1:0] limit,
  // One-cycle pulse when the limit is passed
  output logic expired
);

  logic [`MCT_LIMIT_W-1:0] count; // Cycles waited so far
  logic fired; // Holds off repeated pulses in one wait
  wire over = run && !fired && (count >= limit); // Wait has run past the limit

  // Count master clock cycles while waiting for the next block
  always_ff @(posedge aclk) begin
    if (!aresetn || restart || !run) begin
      count <= '0;
      fired <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= over;
      fired <= fired | over;
      if (!over && !fired) begin
        count <= count + 1'b1;
      end
    end
  end

endmodule : mct_timeout

// ==== mct_top.sv ====
// Register slave, write protection and data timeout of the card interface
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mct_defs.svh"
module mct_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Data path handshake from the card data machine
  input wire logic block_wait,
  input wire logic block_done,
  // Card configuration and interrupt
  output mct_pkg::mct_cfg_s card_cfg,
  output logic data_timeout_error,
  output logic irq
);

  import mct_pkg::*;

  // Register state

  logic [3:0] timeout_cycle_count; // Cycle count field
  logic [2:0] timeout_multiplier_select; // Multiplier code
  mct_slot_e card_slot_select; // Selected card slot
  mct_busw_e card_bus_width; // Selected bus width
  logic protect_enable; // Write protection on
  logic [1:0] irq_mask; // Interrupt mask, status layout
  logic [1:0] status_flags; // Sticky status bits
  logic [1:0] status_clr; // Write-one-to-clear strobes
  logic [1:0] status_set; // Hardware event strobes
  logic dto_pulse; // Timeout expiry pulse

  // Write channel capture

  mct_wr_e wr_state; // Write sequencer state
  logic [31:0] aw_addr; // Captured write address
  logic aw_full; // Write address held
  logic [31:0] w_data; // Captured write data
  logic [3:0] w_strb; // Captured byte strobes
  logic w_full; // Write data held

  // Address and data handshakes
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire b_hs = s_axi_bvalid && s_axi_bready;

  // A write is performed once both halves are held
  wire wr_go = (wr_state == MCT_WR_COLLECT) && aw_full && w_full;

  // Write address decode
  wire wsel_tmo = (aw_addr == `MCT_ADDR_TIMEOUT);
  wire wsel_sdw = (aw_addr == `MCT_ADDR_SLOTWID);
  wire wsel_wpm = (aw_addr == `MCT_ADDR_PROTECT);
  wire wsel_sts = (aw_addr == `MCT_ADDR_STATUS);
  wire wsel_msk = (aw_addr == `MCT_ADDR_IMASK);
  // Any other address is answered with an error
  wire wsel_any = wsel_tmo | wsel_sdw | wsel_wpm | wsel_sts | wsel_msk;

  // Byte-lane mask from strobes
  wire [31:0] lane_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // Current contents of the written register, for partial writes
  wire [31:0] cur_tmo = {25'h0, timeout_multiplier_select, timeout_cycle_count};
  wire [31:0] cur_sdw = {24'h0, card_bus_width, 4'h0, card_slot_select};
  wire [31:0] cur_wpm = {31'h0, protect_enable};

  // Merged words after applying byte strobes
  wire [31:0] new_tmo = (w_data & lane_mask) | (cur_tmo & ~lane_mask);
  wire [31:0] new_sdw = (w_data & lane_mask) | (cur_sdw & ~lane_mask);
  wire [31:0] new_wpm = w_data & lane_mask; // Unwritten key bytes count as zero

  // Merged mask bits, only the low byte holds any
  wire [1:0] new_msk = (w_data[1:0] & lane_mask[1:0]) | (irq_mask & ~lane_mask[1:0]);

  // Key check for the protection register
  // A wrong key leaves the enable bit alone; no other bit is stored here
  wire key_ok = (new_wpm[`MCT_KEY_MSB:`MCT_KEY_LSB] == `MCT_KEY_VALUE);

  // Register write enables
  // Locked writes still get an OKAY answer; they are only dropped
  wire we_tmo = wr_go && wsel_tmo && !protect_enable;
  wire we_sdw = wr_go && wsel_sdw && !protect_enable;
  wire we_wpm = wr_go && wsel_wpm && key_ok;
  wire we_sts = wr_go && wsel_sts;
  wire we_msk = wr_go && wsel_msk;

  // Write response code
  wire [1:0] wr_resp = wsel_any ? `MCT_RESP_OKAY : `MCT_RESP_SLVERR;

  // Write address register and its ready
  // Ready falls on the take and rises after the response: one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 32'h0;
      s_axi_awready <= 1'b0;
    end else if (aw_hs) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (b_hs) begin
      aw_full <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_full) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data register and its ready
  // Strobes are kept with the data so the merge sees the bytes of this write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (w_hs) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (b_hs) begin
      w_full <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_full) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write sequencer and response channel
  // The response code follows from the captured address alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= MCT_WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MCT_RESP_OKAY;
    end else begin
      case (wr_state)
        // Wait for both address and data
        MCT_WR_COLLECT: begin
          if (wr_go) begin
            wr_state <= MCT_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
          end
        end
        // Hold the response until taken
        MCT_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= MCT_WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        // Recover from an illegal code
        default: begin
          wr_state <= MCT_WR_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Configuration registers

  // Timeout setting, ignored while protected
  // Both timeout fields move together in one write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_cycle_count <= `MCT_CFG_RESET;
      timeout_multiplier_select <= 3'h0;
    end else if (we_tmo) begin
      timeout_cycle_count <= new_tmo[`MCT_CYC_MSB:`MCT_CYC_LSB];
      timeout_multiplier_select <= new_tmo[`MCT_MUL_MSB:`MCT_MUL_LSB];
    end
  end

  // Slot and bus width, ignored while protected
  // Reserved width code one is stored as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      card_slot_select <= MCT_SLOT_A;
      card_bus_width <= MCT_BUS_1BIT;
    end else if (we_sdw) begin
      card_slot_select <= mct_slot_e'(new_sdw[`MCT_SLOT_MSB:`MCT_SLOT_LSB]);
      card_bus_width <= mct_busw_e'(new_sdw[`MCT_BUSW_MSB:`MCT_BUSW_LSB]);
    end
  end

  // Protection enable, changed only with the right key
  // This register is never locked itself, or a lock could not be lifted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      protect_enable <= 1'b0;
    end else if (we_wpm) begin
      protect_enable <= new_wpm[`MCT_PEN_BIT];
    end
  end

  // Interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= 2'h0;
    end else if (we_msk) begin
      irq_mask <= new_msk;
    end
  end

  // Data timeout and status

  // Multiplier code to shift amount
  // Each code picks a power-of-two multiplier, so a shift does the product
  logic [4:0] mul_shift;
  always_comb begin
    case (timeout_multiplier_select)
      3'h0: mul_shift = `MCT_SHIFT_0;
      3'h1: mul_shift = `MCT_SHIFT_1;
      3'h2: mul_shift = `MCT_SHIFT_2;
      3'h3: mul_shift = `MCT_SHIFT_3;
      3'h4: mul_shift = `MCT_SHIFT_4;
      3'h5: mul_shift = `MCT_SHIFT_5;
      3'h6: mul_shift = `MCT_SHIFT_6;
      default: mul_shift = `MCT_SHIFT_7;
    endcase
  end

  // Timeout limit in master clock cycles
  wire [`MCT_LIMIT_W-1:0] tmo_limit =
    `MCT_LIMIT_W'({20'h0, timeout_cycle_count} << mul_shift);

  // Counter runs during the gap between blocks
  // A new limit takes hold at once, so change it between blocks
  // A done pulse or a drop of the wait starts the count afresh
  mct_timeout mct_timeout_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(block_wait),
    .restart(block_done),
    .limit(tmo_limit),
    .expired(dto_pulse)
  );

  // Status events and clears
  assign status_set = {1'b0, dto_pulse};
  assign status_clr = we_sts ? (w_data[1:0] & lane_mask[1:0]) : 2'h0;

  // Sticky status flags
  // Set wins over clear, so an expiry in the clearing cycle is kept
  mct_sticky #(
    .W(2)
  ) mct_sticky_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(status_set),
    .clr(status_clr),
    .flag(status_flags)
  );

  // Registered outputs toward the card interface
  // Error and interrupt outputs trail the sticky flag by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      card_cfg <= '0;
      data_timeout_error <= 1'b0;
      irq <= 1'b0;
    end else begin
      card_cfg <= {card_slot_select, card_bus_width, timeout_multiplier_select,
                   timeout_cycle_count};
      data_timeout_error <= status_flags[`MCT_ST_DTO_BIT];
      irq <= |(status_flags & irq_mask);
    end
  end

  // Read channel

  // Read address decode
  // The address is decoded live; it stands with arvalid until taken
  wire rsel_tmo = (s_axi_araddr == `MCT_ADDR_TIMEOUT);
  wire rsel_sdw = (s_axi_araddr == `MCT_ADDR_SLOTWID);
  wire rsel_wpm = (s_axi_araddr == `MCT_ADDR_PROTECT);
  wire rsel_sts = (s_axi_araddr == `MCT_ADDR_STATUS);
  wire rsel_msk = (s_axi_araddr == `MCT_ADDR_IMASK);
  wire rsel_any = rsel_tmo | rsel_sdw | rsel_wpm | rsel_sts | rsel_msk;

  // Status word with live wait indication
  // Bit one is not sticky: it shows the wait as it stands now
  wire [31:0] sts_word = {30'h0, block_wait, status_flags[`MCT_ST_DTO_BIT]};

  // Read data selection, key field reads as zero
  // Key bytes are never stored, so they always read back as zero
  wire [31:0] rd_word =
    rsel_tmo ? cur_tmo :
    rsel_sdw ? cur_sdw :
    rsel_wpm ? cur_wpm :
    rsel_sts ? sts_word :
    rsel_msk ? {30'h0, irq_mask} : 32'h0;

  // Unmapped reads answer zero with an error
  wire [1:0] rd_resp = rsel_any ? `MCT_RESP_OKAY : `MCT_RESP_SLVERR;

  // Read handshake
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  // One read at a time: address taken, data the next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `MCT_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : mct_top

// ==== mct_top_tb.sv ====
// Self-checking bench of the card timeout and configuration block
`timescale 1ns/1ps
`include "mct_defs.svh"
module mct_top_tb;
  import mct_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bw, bd, dte, irq, busy;
  logic req = 1'b0;
  logic [1:0] bresp, rresp;
  logic [23:0] gap = '0;
  logic [3:0] wstrb = 4'hf;
  mct_cfg_s cfg;
  int failures = 0;
  int checked = 0;
  // Multiplier of each code
  int unsigned mul [8] = '{1, 16, 128, 256, 1024, 4096, 65536, 1048576};
  mct_top mct_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .block_wait(bw),
    .block_done(bd), .card_cfg(cfg), .data_timeout_error(dte), .irq(irq));
  mct_card_model mct_card_model_i (.aclk(aclk), .aresetn(aresetn), .req(req), .gap(gap),
    .block_wait(bw), .block_done(bd), .busy(busy));
  initial forever #5 aclk = ~aclk;
  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict and stop
  task automatic end_sim;
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Register write, response compared
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1;
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
      end
    end
    if (!done) chk(32'h0, 32'h1);
  endtask : wr
  // Register read, data and response compared
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1;
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
      end
    end
    if (!done) chk(32'h0, 32'h1);
  endtask : rd
  // Let the card model wait g plus one cycles
  task automatic run_gap(input int unsigned g);
    @(posedge aclk);
    gap <= g[23:0];
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    @(posedge aclk);
    for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(posedge aclk);
    chk(32'(busy), 32'h0);
  endtask : run_gap
  // Watchdog
  initial begin
    #1000000;
    failures++;
    end_sim();
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    int unsigned c;
    void'($urandom(32'hab093792));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'(cfg), 32'h0);
    rd(`MCT_ADDR_TIMEOUT, 32'h0, `MCT_RESP_OKAY);
    rd(`MCT_ADDR_PROTECT, 32'h0, `MCT_RESP_OKAY);
    // Every slot and width code, random junk in unused bits
    for (int i = 0; i < 16; i++) begin
      d = ($urandom & 32'hffffff3c) | i[1:0] | {i[3:2], 6'h0};
      wr(`MCT_ADDR_SLOTWID, d, `MCT_RESP_OKAY);
      rd(`MCT_ADDR_SLOTWID, d & 32'hc3, `MCT_RESP_OKAY);
      chk(32'(cfg.card_slot_select), 32'(i[1:0]));
      chk(32'(cfg.card_bus_width), 32'(i[3:2]));
    end
    // Every multiplier code
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[6:4] = i[2:0];
      wr(`MCT_ADDR_TIMEOUT, d, `MCT_RESP_OKAY);
      rd(`MCT_ADDR_TIMEOUT, d & 32'h7f, `MCT_RESP_OKAY);
      chk(32'(cfg.timeout_multiplier_select), 32'(i[2:0]));
      chk(32'(cfg.timeout_cycle_count), 32'(d[3:0]));
    end
    // Lock sequence with a near-miss key and a random wrong key
    wr(`MCT_ADDR_TIMEOUT, 32'h12, `MCT_RESP_OKAY);
    wr(`MCT_ADDR_SLOTWID, 32'h80, `MCT_RESP_OKAY);
    wr(`MCT_ADDR_PROTECT, {`MCT_KEY_VALUE ^ 24'h1, 8'h01}, `MCT_RESP_OKAY);
    rd(`MCT_ADDR_PROTECT, 32'h0, `MCT_RESP_OKAY);
    wr(`MCT_ADDR_PROTECT, {`MCT_KEY_VALUE, 8'h01}, `MCT_RESP_OKAY);
    rd(`MCT_ADDR_PROTECT, 32'h1, `MCT_RESP_OKAY);
    wr(`MCT_ADDR_TIMEOUT, 32'h25, `MCT_RESP_OKAY);
    wr(`MCT_ADDR_SLOTWID, 32'h41, `MCT_RESP_OKAY);
    rd(`MCT_ADDR_TIMEOUT, 32'h12, `MCT_RESP_OKAY);
    rd(`MCT_ADDR_SLOTWID, 32'h80, `MCT_RESP_OKAY);
    wr(`MCT_ADDR_PROTECT, {24'($urandom % `MCT_KEY_VALUE), 8'h00}, `MCT_RESP_OKAY);
    rd(`MCT_ADDR_PROTECT, 32'h1, `MCT_RESP_OKAY);
    wr(`MCT_ADDR_PROTECT, {`MCT_KEY_VALUE, 8'h00}, `MCT_RESP_OKAY);
    rd(`MCT_ADDR_PROTECT, 32'h0, `MCT_RESP_OKAY);
    // Unmapped place
    rd(32'h4000_0010, 32'h0, `MCT_RESP_SLVERR);
    wr(32'h4000_0010, $urandom, `MCT_RESP_SLVERR);
    // Unwritten bytes keep their contents
    wstrb <= 4'h0;
    wr(`MCT_ADDR_TIMEOUT, $urandom, `MCT_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`MCT_ADDR_TIMEOUT, 32'h12, `MCT_RESP_OKAY);
    // Timeout below and above the limit for six codes, interrupt unmasked
    wr(`MCT_ADDR_IMASK, 32'h1, `MCT_RESP_OKAY);
    for (int m = 0; m < 6; m++) begin
      c = (m < 4) ? 8 + $urandom % 8 : 1;
      wr(`MCT_ADDR_TIMEOUT, {25'h0, m[2:0], c[3:0]}, `MCT_RESP_OKAY);
      run_gap(c * mul[m] / 2);
      rd(`MCT_ADDR_STATUS, 32'h0, `MCT_RESP_OKAY);
      run_gap(c * mul[m] + 8);
      rd(`MCT_ADDR_STATUS, 32'h1, `MCT_RESP_OKAY);
      chk(32'(dte), 32'h1);
      chk(32'(irq), 32'h1);
      wr(`MCT_ADDR_STATUS, 32'h1, `MCT_RESP_OKAY);
      rd(`MCT_ADDR_STATUS, 32'h0, `MCT_RESP_OKAY);
      chk(32'(irq), 32'h0);
    end
    // Masked event still sets the flag
    wr(`MCT_ADDR_IMASK, 32'h0, `MCT_RESP_OKAY);
    wr(`MCT_ADDR_TIMEOUT, 32'h5, `MCT_RESP_OKAY);
    run_gap(4);
    rd(`MCT_ADDR_STATUS, 32'h0, `MCT_RESP_OKAY);
    run_gap(5);
    rd(`MCT_ADDR_STATUS, 32'h1, `MCT_RESP_OKAY);
    chk(32'(irq), 32'h0);
    end_sim();
  end
endmodule : mct_top_tb
